// >>> common/mss_cfg.svh
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH

// ****************
// register offsets
// ****************
`define MSS_A_STOP_MODE 4'h0
`define MSS_A_LOSS_MODE 4'h1
`define MSS_A_INJ_LEVEL 4'h2
`define MSS_A_INJ_TIME 4'h3
`define MSS_A_CTRL 4'h4
`define MSS_A_POS_MODE 4'h5
`define MSS_A_ZS_THRESH 4'h6
`define MSS_A_STATUS 4'h7

// ****************
// control fields
// ****************
`define MSS_B_CLOSED 0
`define MSS_B_ENABLE 1
`define MSS_B_HOLD_ZS 2
`define MSS_B_RAMP_EN 3

// ****************
// reset values
// ****************
`define MSS_R_STOP_MODE 8'h01
`define MSS_R_LOSS_MODE 8'h00
`define MSS_R_INJ_LEVEL 8'h00
`define MSS_R_INJ_TIME 16'h0064
`define MSS_R_CTRL 4'ha
`define MSS_R_POS_MODE 8'h00
`define MSS_R_ZS_THRESH 16'h0000

// ****************
// mode codes
// ****************
`define MSS_OL_COAST 8'h00
`define MSS_OL_RAMP 8'h01
`define MSS_OL_RAMP_DC 8'h02
`define MSS_OL_DC_ZS 8'h03
`define MSS_OL_DC_TIMED 8'h04
`define MSS_OL_DISABLE 8'h05
`define MSS_CL_COAST 8'h00
`define MSS_CL_RAMP 8'h01
`define MSS_CL_NO_RAMP 8'h02
`define MSS_LOSS_OFF 8'h00
`define MSS_POS_ORIENT 8'h01

// ****************
// timing
// ****************
`define MSS_CLK_NS 10
`define MSS_TICK_NS 1000000
`define MSS_TICK_CYC (`MSS_TICK_NS / `MSS_CLK_NS)
`define MSS_HOLD_S 1
`define MSS_HOLD_MS (`MSS_HOLD_S * 1000)
`define MSS_ZS_MS 16
`define MSS_TICK_MS 1

`endif

// >>> common/mss_pkg.sv
package mss_pkg;
    typedef enum logic [2:0] {
        ST_READY = 3'h0,
        ST_RUN = 3'h1,
        ST_PH1 = 3'h2,
        ST_PH2 = 3'h3,
        ST_BLOCK = 3'h4,
        ST_ZSLOT = 3'h5,
        ST_TRIP = 3'h6
    } mss_state_t;
endpackage

// >>> common/mss_tmr_if.sv
`timescale 1ns/1ps
interface mss_tmr_if;
    logic start;
    logic [15:0] load;
    logic done;
    modport ctl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface

// >>> core/mss_sync.sv
`timescale 1ns/1ps
module mss_sync #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// >>> core/mss_timer.sv
`timescale 1ns/1ps
module mss_timer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control sample enable
    input wire logic tick,
    // control side
    mss_tmr_if.tmr bus
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;

    // counts control ticks, so a phase may end up to one tick early
    always_comb begin
        next_cnt = cnt;
        if (bus.start) begin
            next_cnt = bus.load;
        end else if (tick && cnt != 16'h0000) begin
            next_cnt = cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign bus.done = (cnt == 16'h0000) && !bus.start;

    a_timer_load: assert property (@(posedge clk_sys) disable iff (rst)
        bus.start && bus.load != 16'h0000 |=> !bus.done)
        else $error("timer done right after a load");
endmodule

// >>> core/motor_stop_sequencer.sv
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "mss_cfg.svh"

module motor_stop_sequencer
    import mss_pkg::*;
#(
    parameter int TICK_CYC = `MSS_TICK_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // pins from power stage and terminals
    input wire logic runCmd,
    input wire logic secureEnable,
    input wire logic lowSpeed,
    input wire logic dcBusLow,
    input wire logic tripIn,
    // same-clock feedback
    input wire logic [15:0] speedFb,
    input wire logic rampAtZero,
    // requests to the inverter
    output logic inverterEnable,
    output logic rampStop,
    output logic rampForce,
    output logic noRampStop,
    output logic dcInject,
    output logic lfInject,
    output logic [7:0] injectLevel,
    output logic orientStop,
    output logic uvTrip,
    output logic driveReady
);
    // ****************
    // registers
    // ****************
    logic [7:0] stopMode, lossMode, posMode;
    logic [7:0] next_stopMode, next_lossMode, next_posMode, next_injectLevel;
    logic [15:0] injTime, zsThresh, next_injTime, next_zsThresh, next_rdData;
    logic [3:0] ctrl, next_ctrl;
    mss_state_t state, next_state;
    logic [7:0] mode, next_mode;

    always_comb begin
        next_stopMode = stopMode;
        next_lossMode = lossMode;
        next_injectLevel = injectLevel;
        next_injTime = injTime;
        next_ctrl = ctrl;
        next_posMode = posMode;
        next_zsThresh = zsThresh;
        next_rdData = 16'h0000;
        if (regWr) begin
            case (regAddr)
                `MSS_A_STOP_MODE: next_stopMode = regWrData[7:0];
                `MSS_A_LOSS_MODE: next_lossMode = regWrData[7:0];
                `MSS_A_INJ_LEVEL: next_injectLevel = regWrData[7:0];
                `MSS_A_INJ_TIME: next_injTime = regWrData;
                `MSS_A_CTRL: next_ctrl = regWrData[3:0];
                `MSS_A_POS_MODE: next_posMode = regWrData[7:0];
                `MSS_A_ZS_THRESH: next_zsThresh = regWrData;
                default: ;
            endcase
        end
        if (regRd) begin
            case (regAddr)
                `MSS_A_STOP_MODE: next_rdData = {8'h00, stopMode};
                `MSS_A_LOSS_MODE: next_rdData = {8'h00, lossMode};
                `MSS_A_INJ_LEVEL: next_rdData = {8'h00, injectLevel};
                `MSS_A_INJ_TIME: next_rdData = injTime;
                `MSS_A_CTRL: next_rdData = {12'h000, ctrl};
                `MSS_A_POS_MODE: next_rdData = {8'h00, posMode};
                `MSS_A_ZS_THRESH: next_rdData = zsThresh;
                `MSS_A_STATUS: next_rdData = {4'h0, mode[3:0], 1'b0, state,
                    uvTrip, driveReady, dcInject, inverterEnable};
                default: next_rdData = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stopMode <= `MSS_R_STOP_MODE;
            lossMode <= `MSS_R_LOSS_MODE;
            injectLevel <= `MSS_R_INJ_LEVEL;
            injTime <= `MSS_R_INJ_TIME;
            ctrl <= `MSS_R_CTRL;
            posMode <= `MSS_R_POS_MODE;
            zsThresh <= `MSS_R_ZS_THRESH;
            regRdData <= 16'h0000;
        end else begin
            stopMode <= next_stopMode;
            lossMode <= next_lossMode;
            injectLevel <= next_injectLevel;
            injTime <= next_injTime;
            ctrl <= next_ctrl;
            posMode <= next_posMode;
            zsThresh <= next_zsThresh;
            regRdData <= next_rdData;
        end
    end

    // ****************
    // inputs and control tick
    // ****************
    logic [4:0] pinS;
    logic runS, enS, lowS, busLowS, tripS;
    logic [31:0] tickCnt, next_tickCnt;
    logic tick;

    mss_sync #(.W(5)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .din({runCmd, secureEnable, lowSpeed, dcBusLow, tripIn}),
        .dout(pinS)
    );
    assign {runS, enS, lowS, busLowS, tripS} = pinS;

    assign tick = (tickCnt == 32'(TICK_CYC - 1));

    always_comb begin
        next_tickCnt = tick ? 32'h0000_0000 : tickCnt + 32'h0000_0001;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tickCnt <= 32'h0000_0000;
        end else begin
            tickCnt <= next_tickCnt;
        end
    end

    // ****************
    // timers
    // ****************
    mss_tmr_if tmrA ();
    mss_tmr_if tmrZ ();
    logic closed, enableOk, holdZs, orientSel, tripAny, zsBelow, enterPh1;

    assign closed = ctrl[`MSS_B_CLOSED];
    assign enableOk = enS && ctrl[`MSS_B_ENABLE];
    assign holdZs = ctrl[`MSS_B_HOLD_ZS];
    assign orientSel = (posMode == `MSS_POS_ORIENT);
    assign tripAny = tripS || uvTrip;
    assign zsBelow = (speedFb < zsThresh);

    assign tmrZ.start = !zsBelow || enterPh1;
    assign tmrZ.load = 16'(`MSS_ZS_MS / `MSS_TICK_MS + 1);

    mss_timer u_tmr_a (.clk_sys(clk_sys), .rst(rst), .tick(tick), .bus(tmrA));
    mss_timer u_tmr_z (.clk_sys(clk_sys), .rst(rst), .tick(tick), .bus(tmrZ));

    // ****************
    // stop sequencer
    // ****************
    logic olStop, oneShot;

    assign olStop = !closed && !orientSel;
    // MSS_OL_DC_ZS and MSS_OL_DC_TIMED stops must reach ready first
    assign oneShot = olStop && (mode == `MSS_OL_DC_ZS || mode == `MSS_OL_DC_TIMED);

    always_comb begin
        next_state = state;
        next_mode = mode;
        enterPh1 = 1'b0;
        tmrA.start = 1'b0;
        tmrA.load = 16'(`MSS_HOLD_MS / `MSS_TICK_MS + 1);
        unique case (state)
            ST_READY: begin
                if (!tripAny && runS && enableOk) next_state = ST_RUN;
            end
            ST_RUN: begin
                next_mode = stopMode;
                if (tripAny) begin
                    next_state = ST_TRIP;
                end else if (!enableOk) begin
                    next_state = closed ? ST_READY : ST_BLOCK;
                    tmrA.start = !closed;
                end else if (!runS) begin
                    next_state = ST_PH1;
                    enterPh1 = 1'b1;
                    if (orientSel) begin
                        next_state = ST_PH1;
                    end else if (closed) begin
                        if (stopMode == `MSS_CL_COAST && holdZs) next_state = ST_ZSLOT;
                    end else if (stopMode == `MSS_OL_DISABLE) begin
                        next_state = ST_READY;
                    end else if (stopMode == `MSS_OL_DC_TIMED) begin
                        tmrA.start = 1'b1;
                        tmrA.load = injTime + 16'h0001;
                    end else if (stopMode != `MSS_OL_RAMP && stopMode != `MSS_OL_RAMP_DC
                        && stopMode != `MSS_OL_DC_ZS) begin
                        next_state = ST_BLOCK;
                        tmrA.start = 1'b1;
                    end
                end
            end
            ST_PH1: begin
                if (!olStop) begin
                    if (tmrZ.done) next_state = ST_READY;
                end else if (mode == `MSS_OL_RAMP) begin
                    if (rampAtZero) begin
                        next_state = ST_PH2;
                        tmrA.start = 1'b1;
                    end
                end else if (mode == `MSS_OL_RAMP_DC) begin
                    if (rampAtZero) begin
                        next_state = ST_PH2;
                        tmrA.start = 1'b1;
                        tmrA.load = injTime + 16'h0001;
                    end
                end else if (mode == `MSS_OL_DC_ZS) begin
                    if (lowS) begin
                        next_state = ST_PH2;
                        tmrA.start = 1'b1;
                        tmrA.load = injTime + 16'h0001;
                    end
                end else if (tmrA.done) begin
                    next_state = ST_READY;
                end
            end
            ST_PH2: begin
                if (tmrA.done) next_state = ST_READY;
            end
            ST_BLOCK: begin
                if (tmrA.done) next_state = ST_READY;
            end
            ST_ZSLOT: begin
                if (tick) begin
                    next_state = ST_PH1;
                    enterPh1 = 1'b1;
                end
            end
            ST_TRIP: begin
                if (!tripAny) next_state = ST_READY;
            end
            default: next_state = ST_READY;
        endcase
        if (state == ST_PH1 || state == ST_PH2 || state == ST_ZSLOT) begin
            if (runS && enableOk && !oneShot && state != ST_ZSLOT) next_state = ST_RUN;
            if (tripAny) begin
                next_state = ST_TRIP;
            end else if (!enableOk) begin
                next_state = closed ? ST_READY : ST_BLOCK;
                tmrA.start = !closed;
                tmrA.load = 16'(`MSS_HOLD_MS / `MSS_TICK_MS + 1);
            end
        end
    end

    // ****************
    // request outputs
    // ****************
    logic next_inv, next_ramp, next_force, next_noRamp, next_dc, next_lf, next_orient;
    logic next_uv, nOl, ph1, ph2;

    always_comb begin
        nOl = !closed && !orientSel;
        ph1 = (next_state == ST_PH1);
        ph2 = (next_state == ST_PH2);
        // coast inhibits unless holding zero speed
        next_inv = (next_state == ST_RUN) || ph2 || (ph1 && (nOl
            || orientSel || next_mode != `MSS_CL_COAST || holdZs));
        next_ramp = ph1 && !orientSel && (nOl ? (next_mode == `MSS_OL_RAMP
            || next_mode == `MSS_OL_RAMP_DC) : next_mode != `MSS_CL_NO_RAMP);
        // ramp stop forced past ramp enable
        next_force = next_ramp && !ctrl[`MSS_B_RAMP_EN];
        next_noRamp = ph1 && !nOl && !orientSel && next_mode == `MSS_CL_NO_RAMP;
        next_dc = nOl && ((ph2 && next_mode != `MSS_OL_RAMP)
            || (ph1 && next_mode == `MSS_OL_DC_TIMED));
        next_lf = ph1 && nOl && next_mode == `MSS_OL_DC_ZS;
        next_orient = ph1 && orientSel;
        // no supply loss handling, trip on low bus
        next_uv = (lossMode == `MSS_LOSS_OFF) && busLowS;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_READY;
            mode <= 8'h00;
            {inverterEnable, rampStop, rampForce, noRampStop} <= 4'h0;
            {dcInject, lfInject, orientStop, uvTrip} <= 4'h0;
            driveReady <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            {inverterEnable, rampStop, rampForce, noRampStop} <=
                {next_inv, next_ramp, next_force, next_noRamp};
            {dcInject, lfInject, orientStop, uvTrip} <= {next_dc, next_lf, next_orient, next_uv};
            driveReady <= (next_state == ST_READY);
        end
    end

    // ****************
    // checks
    // ****************
    a_coast_block: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_RUN && !tripAny && enableOk && !runS && olStop && stopMode == `MSS_OL_COAST
        |=> state == ST_BLOCK && !inverterEnable) else $error("coast did not block");
    a_block_holds: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_BLOCK && !tmrA.done |=> state == ST_BLOCK && !inverterEnable)
        else $error("re-enable during block");
    a_ramp_hold: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_PH2 && olStop && mode == `MSS_OL_RAMP |-> inverterEnable && !dcInject)
        else $error("ramp hold lost inverter");
    a_ramp_inject: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_PH1 && olStop && mode == `MSS_OL_RAMP_DC && rampAtZero && !runS
        && enableOk && !tripAny |=> state == ST_PH2 && dcInject) else $error("no injection");
    a_lf_inject: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_PH1 && olStop && mode == `MSS_OL_DC_ZS |-> lfInject && !dcInject)
        else $error("low frequency injection missing");
    a_timed_only: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_PH1 && olStop && mode == `MSS_OL_DC_TIMED && tmrA.done && enableOk
        && !tripAny |=> state == ST_READY) else $error("timed stop overran");
    a_disable_now: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_RUN && !tripAny && enableOk && !runS && olStop && stopMode == `MSS_OL_DISABLE
        |=> state == ST_READY && !inverterEnable) else $error("disable not immediate");
    a_no_restart: assert property (@(posedge clk_sys) disable iff (rst)
        (state == ST_PH1 || state == ST_PH2) && oneShot |=> state != ST_RUN)
        else $error("restart before ready");
    a_zero_speed: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_PH1 && !olStop && !tmrZ.done && enableOk && !tripAny && !runS
        |=> state == ST_PH1) else $error("stop declared early");
    a_hold_slot: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_ZSLOT && tick && enableOk && !tripAny |-> !inverterEnable ##1 inverterEnable)
        else $error("hold slot wrong");
    a_uv_trip: assert property (@(posedge clk_sys) disable iff (rst)
        lossMode == `MSS_LOSS_OFF && busLowS |=> uvTrip ##1 state != ST_RUN)
        else $error("undervoltage not tripped");
endmodule

// >>> testbench/mss_power_stage.sv
`timescale 1ns/1ps
// ****************
// power stage and speed feedback model
// ****************
// speed climbs while the inverter runs free, decays under any stop request;
// slow pace quarters the decay rate to stretch the speed-dependent waits in the sequencer
module mss_power_stage (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // requests from the sequencer
    input wire logic inverterEnable,
    input wire logic [5:0] stopReq,
    // answer pace
    input wire logic slow,
    // feedback
    output logic [15:0] speedFb,
    output logic rampAtZero,
    output logic lowSpeed
);
    logic [1:0] pace;

    always_ff @(posedge clk_sys) begin
        pace <= pace + 2'h1;
        if (rst) begin
            speedFb <= 16'h0000;
            pace <= 2'h0;
        end else if (inverterEnable && stopReq == 6'h00) begin
            if (speedFb < 16'h0064) begin
                speedFb <= speedFb + 16'h0001;
            end
        end else if ((!slow || pace == 2'h0) && speedFb != 16'h0000) begin
            speedFb <= speedFb - 16'h0001;
        end
    end

    // ramp generator sits at zero once the shaft has stopped
    assign rampAtZero = speedFb == 16'h0000;
    // low speed is only sensed while low-frequency current is injected
    assign lowSpeed = stopReq[4] && speedFb < 16'h000a;
endmodule

// >>> testbench/motor_stop_sequencer_test.sv
`timescale 1ns/1ps
module motor_stop_sequencer_test;
    import mss_pkg::*;
    localparam int TICK = 10;
    localparam int LIMIT = 60000;
    typedef struct packed {logic [3:0] a; logic [15:0] v;} mss_row_t;
    logic clk_sys, rst, regWr, regRd, runCmd, secureEnable, dcBusLow, slow, tripIn;
    logic [3:0] regAddr;
    logic [15:0] regWrData, regRdData, speedFb, d;
    logic lowSpeed, rampAtZero, inverterEnable, rampStop, rampForce, noRampStop;
    logic dcInject, lfInject, orientStop, uvTrip, driveReady;
    logic [7:0] injectLevel;
    wire [8:0] outs = {driveReady, uvTrip, orientStop, lfInject, dcInject, noRampStop,
                       rampForce, rampStop, inverterEnable};
    int nMismatch = 0;
    int checkCount = 0;
    int cyc = 0;
    int n, cnt;
    mss_row_t rows [8] = '{'{4'h0, 16'h0001}, '{4'h1, 16'h0000}, '{4'h2, 16'h0000},
        '{4'h3, 16'h0064}, '{4'h4, 16'h000a}, '{4'h5, 16'h0000}, '{4'h6, 16'h0000},
        '{4'h9, 16'h0000}};

    motor_stop_sequencer #(.TICK_CYC(TICK)) uut (.clk_sys(clk_sys), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .runCmd(runCmd), .secureEnable(secureEnable),
        .lowSpeed(lowSpeed), .dcBusLow(dcBusLow), .tripIn(tripIn), .speedFb(speedFb),
        .rampAtZero(rampAtZero), .inverterEnable(inverterEnable), .rampStop(rampStop),
        .rampForce(rampForce), .noRampStop(noRampStop), .dcInject(dcInject),
        .lfInject(lfInject), .injectLevel(injectLevel), .orientStop(orientStop),
        .uvTrip(uvTrip), .driveReady(driveReady));

    mss_power_stage partner (.clk_sys(clk_sys), .rst(rst), .inverterEnable(inverterEnable),
        .stopReq(outs[6:1]), .slow(slow), .speedFb(speedFb), .rampAtZero(rampAtZero),
        .lowSpeed(lowSpeed));

    // ****************
    // clock and hang guard
    // ****************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            nMismatch++;
            conclude();
        end
    end

    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        v = regRdData;
    endtask

    // bounded wait on one sequencer output; a miss shows up as a mismatch
    task automatic waitOut(input int i, input logic v, input int lim, output int k);
        k = 0;
        while (outs[i] !== v && k < lim) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        chk(outs[i], v);
    endtask

    // start a run in the given stop mode and control setting, then drop run
    task automatic go(input logic [7:0] m, input logic [3:0] c);
        int k;
        wr(4'h0, {8'h00, m});
        wr(4'h4, {12'h000, c});
        @(posedge clk_sys);
        runCmd <= 1'b1;
        waitOut(0, 1'b1, 8, k);
        repeat (120) @(posedge clk_sys);
        rd(4'h7, d);
        chk(d & 16'h0077, 16'h0011);
        @(posedge clk_sys);
        runCmd <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        rst = 1'b1;
        {regWr, regRd, runCmd, dcBusLow, slow, tripIn} = 6'h00;
        secureEnable = 1'b1;
        regAddr = 4'h0;
        regWrData = 16'h0000;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        waitOut(8, 1'b1, 4, n);
        foreach (rows[i]) begin
            rd(rows[i].a, d);
            chk(d, rows[i].v);
        end
        $display("test registers done");
        go(8'h01, 4'ha);
        waitOut(1, 1'b1, 5, n);
        waitOut(1, 1'b0, 300, n);
        chk(outs[0], 1'b1);
        repeat (990 * TICK) @(posedge clk_sys);
        #1;
        chk(outs[0], 1'b1);
        waitOut(8, 1'b1, 20 * TICK, n);
        $display("test ramp stop done");
        go(8'h00, 4'ha);
        waitOut(0, 1'b0, 5, n);
        @(posedge clk_sys);
        runCmd <= 1'b1;
        repeat (990 * TICK) @(posedge clk_sys);
        #1;
        chk(outs[0], 1'b0);
        waitOut(0, 1'b1, 20 * TICK, n);
        wr(4'h0, 16'h0005);
        @(posedge clk_sys);
        runCmd <= 1'b0;
        waitOut(0, 1'b0, 5, n);
        waitOut(8, 1'b1, 5, n);
        @(posedge clk_sys);
        runCmd <= 1'b1;
        waitOut(0, 1'b1, 6, n);
        @(posedge clk_sys);
        secureEnable <= 1'b0;
        waitOut(0, 1'b0, 6, n);
        @(posedge clk_sys);
        secureEnable <= 1'b1;
        repeat (990 * TICK) @(posedge clk_sys);
        #1;
        chk(outs[0], 1'b0);
        waitOut(0, 1'b1, 20 * TICK, n);
        @(posedge clk_sys);
        runCmd <= 1'b0;
        waitOut(8, 1'b1, 5, n);
        $display("test coast and disable done");
        wr(4'h3, 16'h0005);
        wr(4'h2, 16'h005a);
        go(8'h04, 4'ha);
        waitOut(4, 1'b1, 5, n);
        chk(injectLevel, 8'h5a);
        @(posedge clk_sys);
        runCmd <= 1'b1;
        waitOut(4, 1'b0, 8 * TICK, n);
        chk(16'(n >= 4 * TICK), 16'h0001);
        chk(outs[0], 1'b0);
        waitOut(0, 1'b1, 8, n);
        wr(4'h0, 16'h0003);
        @(posedge clk_sys);
        runCmd <= 1'b0;
        waitOut(5, 1'b1, 5, n);
        waitOut(4, 1'b1, 300, n);
        chk(outs[5], 1'b0);
        waitOut(8, 1'b1, 8 * TICK, n);
        go(8'h02, 4'ha);
        waitOut(1, 1'b1, 5, n);
        waitOut(4, 1'b1, 300, n);
        chk(outs[1], 1'b0);
        waitOut(8, 1'b1, 8 * TICK, n);
        $display("test injection modes done");
        wr(4'h6, 16'h0014);
        slow <= 1'b1;
        go(8'h00, 4'hb);
        // zero speed held 16 ms before ready
        waitOut(0, 1'b0, 5, n);
        cnt = 0;
        while (driveReady !== 1'b1 && cnt < 400) begin
            @(posedge clk_sys);
            #1;
            cnt = (speedFb < 16'h0014) ? cnt + 1 : 0;
        end
        chk(16'(cnt >= 16 * TICK), 16'h0001);
        chk(16'(cnt <= 19 * TICK), 16'h0001);
        slow <= 1'b0;
        go(8'h00, 4'hf);
        waitOut(0, 1'b0, 5, n);
        waitOut(0, 1'b1, TICK + 2, n);
        chk(outs[1], 1'b1);
        waitOut(8, 1'b1, 400, n);
        go(8'h01, 4'h3);
        waitOut(2, 1'b1, 5, n);
        waitOut(8, 1'b1, 400, n);
        go(8'h02, 4'hb);
        waitOut(3, 1'b1, 5, n);
        waitOut(8, 1'b1, 400, n);
        wr(4'h5, 16'h0001);
        go(8'h02, 4'hb);
        waitOut(6, 1'b1, 5, n);
        chk(outs[3], 1'b0);
        waitOut(8, 1'b1, 400, n);
        $display("test closed loop done");
        @(posedge clk_sys);
        dcBusLow <= 1'b1;
        waitOut(7, 1'b1, 5, n);
        @(posedge clk_sys);
        dcBusLow <= 1'b0;
        waitOut(7, 1'b0, 5, n);
        // other loss modes leave the bus watch to their own handling
        wr(4'h1, 16'h0001);
        @(posedge clk_sys);
        dcBusLow <= 1'b1;
        repeat (6) @(posedge clk_sys);
        dcBusLow <= 1'b0;
        #1;
        chk(outs[7], 1'b0);
        $display("test undervoltage done");
        wr(4'h5, 16'h0000);
        go(8'h04, 4'ha);
        // a trip ends a timed injection stop, ready comes first
        waitOut(4, 1'b1, 5, n);
        @(posedge clk_sys);
        {runCmd, tripIn} <= 2'b11;
        waitOut(4, 1'b0, 6, n);
        rd(4'h7, d);
        chk(d & 16'h0077, 16'h0060);
        @(posedge clk_sys);
        tripIn <= 1'b0;
        waitOut(8, 1'b1, 6, n);
        waitOut(0, 1'b1, 6, n);
        // clearing the enable setting blocks 1 s as well
        wr(4'h0, 16'h0005);
        wr(4'h4, 16'h0008);
        waitOut(0, 1'b0, 4, n);
        wr(4'h4, 16'h000a);
        waitOut(0, 1'b1, 1010 * TICK, n);
        chk(16'(n >= 990 * TICK), 16'h0001);
        $display("test trip and enable setting done");
        // reset in the middle of a run
        @(posedge clk_sys);
        {rst, runCmd} <= 2'b10;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk(16'(outs), 16'h0000);
        waitOut(8, 1'b1, 4, n);
        rd(4'h0, d);
        chk(d, 16'h0001);
        chk(injectLevel, 8'h00);
        $display("test reset in run done");
        conclude();
    end
endmodule
